// File: src/rtcsw_defs.vh
// constants for the clock system word setup block
// Summary of operation
// - handshake byte bits may change between any two statements, not per scan.
// - no default locations; clock stays off until valid location words are written.
// - area selector bytes hold ascii D for data block or F for flags.
// - block bytes hold data block 2 to 255, or a flag byte address.
// - data word bytes give start word 0 to 255, used only for data blocks.
// - signed correction -400 to +400, read, checked and applied once per hour.
// - on parameter setting, check clock access and start; report in word 11 bits 0,1.
// - correction out of range sets word 11 bit 15 and zero correction is applied.
`ifndef RTCSW_DEFS_VH
`define RTCSW_DEFS_VH
`define RTCSW_ADDR_LOC_CLK 16'hea10
`define RTCSW_ADDR_LOC_MID 16'hea12
`define RTCSW_ADDR_LOC_STS 16'hea14
`define RTCSW_ADDR_CHECK 16'hea16
`define RTCSW_ADDR_CORR 16'hea18
`define RTCSW_SEL_DB 8'h44
`define RTCSW_SEL_FLAG 8'h46
`define RTCSW_DB_MIN 8'h02
`define RTCSW_CORR_MAX 16'sd400
`define RTCSW_CORR_MIN (-16'sd400)
`define RTCSW_CHK_ACCESS_BIT 0
`define RTCSW_CHK_START_BIT 1
`define RTCSW_CHK_CORR_BIT 15
`define RTCSW_HOUR_S 3600
`define RTCSW_CLK_HZ 50000000
`define RTCSW_HOUR_CYCLES 38'd180000000000
`define RTCSW_START_TIMEOUT 16'h03e8
`endif

// File: src/rtcsw_hour_tick.v
// hourly tick generator for the drift correction
`timescale 1ns/10ps
`default_nettype none
`include "rtcsw_defs.vh"
module rtcsw_hour_tick #(
    parameter [37:0] HOUR_CYCLES = `RTCSW_HOUR_CYCLES
) (
    input wire i_clk,
    input wire i_resetn,
    output reg o_tick
);
    reg [37:0] cnt_reg;
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            cnt_reg <= 38'h0;
            o_tick <= 1'b0;
        end else if (cnt_reg == HOUR_CYCLES - 38'd1) begin
            cnt_reg <= 38'h0;
            o_tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 38'd1;
            o_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: src/rtcsw_top.v
// clock system word registers, start-up check and hourly correction
`timescale 1ns/10ps
`default_nettype none
`include "rtcsw_defs.vh"
module rtcsw_top #(
    parameter [37:0] HOUR_CYCLES = `RTCSW_HOUR_CYCLES
) (
    input wire I_CLK_SYS,
    input wire I_RESETN,
    input wire [15:0] I_ADDR,
    input wire [15:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    input wire I_CLK_ACK,
    input wire I_CLK_RUNNING,
    output reg [15:0] O_RDATA,
    output reg O_CLK_ENABLE,
    output reg O_CORR_STROBE,
    output reg [15:0] O_CORR_VALUE
);
    // start-up check states
    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_RUN = 2'd2;
    // two asynchronous answers from the clock chip
    localparam SYNC_W = 2;

    reg [15:0] loc_clk_reg;
    reg [15:0] loc_mid_reg;
    reg [15:0] loc_sts_reg;
    // bits 1:0 change only on a check, bit 15 every hour
    reg [15:0] check_reg;
    reg [15:0] corr_reg;
    reg [1:0] state_reg;
    reg [15:0] wait_reg;

    reg [15:0] check_next;
    reg [1:0] state_next;
    reg [15:0] wait_next;
    reg en_next;
    reg [15:0] rdata_next;

    wire [SYNC_W-1:0] pin_async;
    wire [SYNC_W-1:0] pin_sync;
    wire ack_sync;
    wire run_sync;
    wire hour_tick;
    wire locs_ok;
    wire corr_ok;
    wire param_wr;

    // area selector plus block number check
    function area_ok;
        input [7:0] sel;
        input [7:0] num;
        begin
            area_ok = (sel == `RTCSW_SEL_FLAG) ||
                ((sel == `RTCSW_SEL_DB) && (num >= `RTCSW_DB_MIN));
        end
    endfunction

    // location word decode
    function is_loc_addr;
        input [15:0] a;
        begin
            is_loc_addr = (a == `RTCSW_ADDR_LOC_CLK) || (a == `RTCSW_ADDR_LOC_MID) ||
                (a == `RTCSW_ADDR_LOC_STS);
        end
    endfunction

    assign locs_ok = area_ok(loc_clk_reg[15:8], loc_clk_reg[7:0]) &&
        area_ok(loc_mid_reg[7:0], loc_sts_reg[15:8]);
    assign corr_ok = ($signed(corr_reg) <= `RTCSW_CORR_MAX) &&
        ($signed(corr_reg) >= `RTCSW_CORR_MIN);

    rtcsw_hour_tick #(
        .HOUR_CYCLES(HOUR_CYCLES)
    ) u_tick (
        .i_clk(I_CLK_SYS),
        .i_resetn(I_RESETN),
        .o_tick(hour_tick)
    );

    assign pin_async = {I_CLK_RUNNING, I_CLK_ACK};
    assign ack_sync = pin_sync[0];
    assign run_sync = pin_sync[1];

    // clock chip answers are asynchronous; two flops each
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
            reg s1_reg;
            reg s2_reg;
            always @(posedge I_CLK_SYS) begin
                if (!I_RESETN) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                end else begin
                    s1_reg <= pin_async[gi];
                    s2_reg <= s1_reg;
                end
            end
            // only the second flop feeds logic
            assign pin_sync[gi] = s2_reg;
        end
    endgenerate

    always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            loc_clk_reg <= 16'h0000;
            loc_mid_reg <= 16'h0000;
            loc_sts_reg <= 16'h0000;
            corr_reg <= 16'h0000;
        end else if (I_WR) begin
            case (I_ADDR)
                `RTCSW_ADDR_LOC_CLK: loc_clk_reg <= I_WDATA;
                `RTCSW_ADDR_LOC_MID: loc_mid_reg <= I_WDATA;
                `RTCSW_ADDR_LOC_STS: loc_sts_reg <= I_WDATA;
                `RTCSW_ADDR_CORR: corr_reg <= I_WDATA;
                default: ;
            endcase
        end
    end

    // a correction write must not restart the check
    assign param_wr = I_WR && is_loc_addr(I_ADDR);

    // next state of the start-up supervision
    always @* begin
        state_next = state_reg;
        wait_next = wait_reg;
        check_next = check_reg;
        en_next = O_CLK_ENABLE;
        case (state_reg)
            ST_IDLE, ST_RUN: begin
                // every parameter setting restarts the check
                if (param_wr) begin
                    state_next = ST_WAIT;
                    wait_next = 16'h0000;
                    en_next = 1'b0;
                end
            end
            ST_WAIT: begin
                // timeout counts from the last location write
                if (param_wr) begin
                    wait_next = 16'h0000;
                end else if (!locs_ok) begin
                    state_next = ST_IDLE;
                end else if (ack_sync && run_sync) begin
                    check_next[`RTCSW_CHK_ACCESS_BIT] = 1'b0;
                    check_next[`RTCSW_CHK_START_BIT] = 1'b0;
                    state_next = ST_RUN;
                    en_next = 1'b1;
                end else if (wait_reg == `RTCSW_START_TIMEOUT) begin
                    // failure bits held until the next check ends in success or timeout
                    check_next[`RTCSW_CHK_ACCESS_BIT] = ~ack_sync;
                    check_next[`RTCSW_CHK_START_BIT] = ~run_sync;
                    state_next = ST_IDLE;
                end else begin
                    wait_next = wait_reg + 16'h0001;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // hourly read and check of correction
        if (hour_tick) begin
            check_next[`RTCSW_CHK_CORR_BIT] = ~corr_ok;
        end
    end

    // start-up supervision; clock is off until a check passes
    always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            state_reg <= ST_IDLE;
            wait_reg <= 16'h0000;
            check_reg <= 16'h0000;
            O_CLK_ENABLE <= 1'b0;
        end else begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            check_reg <= check_next;
            O_CLK_ENABLE <= en_next;
        end
    end

    // apply once per hour, zero if invalid
    always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            O_CORR_STROBE <= 1'b0;
            O_CORR_VALUE <= 16'h0000;
        end else begin
            O_CORR_STROBE <= hour_tick && O_CLK_ENABLE;
            // a stopped clock takes no correction; value and strobe move together
            if (hour_tick && O_CLK_ENABLE) begin
                O_CORR_VALUE <= corr_ok ? corr_reg : 16'h0000;
            end
        end
    end

    // reads return live state, no per-scan latching
    always @* begin
        case (I_ADDR)
            `RTCSW_ADDR_LOC_CLK: rdata_next = loc_clk_reg;
            `RTCSW_ADDR_LOC_MID: rdata_next = loc_mid_reg;
            `RTCSW_ADDR_LOC_STS: rdata_next = loc_sts_reg;
            `RTCSW_ADDR_CHECK: rdata_next = check_reg;
            `RTCSW_ADDR_CORR: rdata_next = corr_reg;
            // unmapped words read as zero
            default: rdata_next = 16'h0000;
        endcase
    end

    // read data holds until the next read strobe
    always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            O_RDATA <= 16'h0000;
        end else if (I_RD) begin
            O_RDATA <= rdata_next;
        end
    end
endmodule
`default_nettype wire

// File: test/rtcsw_top_props.sv
// concurrent checks for the clock system word block
`timescale 1ns/10ps
`default_nettype none
module rtcsw_props #(
    parameter [37:0] HOUR_CYCLES = 38'd180000000000
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RESETN,
    input wire logic [15:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic I_CLK_ACK,
    input wire logic I_CLK_RUNNING,
    input wire logic [15:0] O_RDATA,
    input wire logic O_CLK_ENABLE,
    input wire logic O_CORR_STROBE,
    input wire logic [15:0] O_CORR_VALUE
);
    wire w10 = I_WR && I_ADDR == 16'hea10;
    wire [7:0] sl = I_WDATA[15:8];
    wire [15:0] cv = O_CORR_VALUE;
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESETN);
    property p_sel; w10 && sl != 8'h44 && sl != 8'h46 |=> !O_CLK_ENABLE [*8]; endproperty
    a_sel: assert property (p_sel) else $error("clock on with bad selector");
    property p_db; w10 && sl == 8'h44 && I_WDATA[7:0] < 8'h02 |=> !O_CLK_ENABLE [*8]; endproperty
    a_db: assert property (p_db) else $error("clock on with low block");
    // any location write restarts the check
    property p_rst; I_WR && (I_ADDR == 16'hea10 || I_ADDR == 16'hea12 || I_ADDR == 16'hea14)
        |=> !O_CLK_ENABLE;
    endproperty
    a_rst: assert property (p_rst) else $error("clock kept on over write");
    // answers pass two flops and one state step before the enable rises
    property p_on; $rose(O_CLK_ENABLE) |-> $past(I_CLK_ACK, 3) && $past(I_CLK_RUNNING, 3);
    endproperty
    a_on: assert property (p_on) else $error("clock on without start");
    property p_ok; I_RD && !I_WR && I_ADDR == 16'hea16 && O_CLK_ENABLE |=> O_RDATA[1:0] == 0;
    endproperty
    a_ok: assert property (p_ok) else $error("check bits set while on");
    property p_stb; O_CORR_STROBE |=> !O_CORR_STROBE [*8]; endproperty
    a_stb: assert property (p_stb) else $error("strobe too often");
    property p_rng; O_CORR_STROBE |-> $signed(cv) <= 400 && $signed(cv) >= -400; endproperty
    a_rng: assert property (p_rng) else $error("correction out of range");
    property p_app; $changed(O_CORR_VALUE) |-> O_CORR_STROBE; endproperty
    a_app: assert property (p_app) else $error("correction moved off tick");
    c_on: cover property (w10 ##[1:20] $rose(O_CLK_ENABLE));
    c_max: cover property (O_CORR_STROBE && cv == 16'h0190);
    c_rd: cover property (I_RD && I_ADDR == 16'hea16);
endmodule
bind rtcsw_top rtcsw_props #(.HOUR_CYCLES(HOUR_CYCLES)) i_rtcsw_props (.I_CLK_SYS(I_CLK_SYS),
    .I_RESETN(I_RESETN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .I_CLK_ACK(I_CLK_ACK), .I_CLK_RUNNING(I_CLK_RUNNING), .O_RDATA(O_RDATA),
    .O_CLK_ENABLE(O_CLK_ENABLE), .O_CORR_STROBE(O_CORR_STROBE), .O_CORR_VALUE(O_CORR_VALUE));
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the clock system word block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, ack = 0, run = 0;
    logic [15:0] addr = 0, wdata = 0, rv;
    wire [15:0] rdata, cval;
    wire en, stb;
    integer failures = 0, checks_done = 0, n;
    always #10 clk = ~clk;
    // short hour keeps the run small
    rtcsw_top #(.HOUR_CYCLES(38'd50)) i_rtcsw_top (.I_CLK_SYS(clk), .I_RESETN(rst_n),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_CLK_ACK(ack),
        .I_CLK_RUNNING(run), .O_RDATA(rdata), .O_CLK_ENABLE(en), .O_CORR_STROBE(stb),
        .O_CORR_VALUE(cval));
    task stop_test;
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task wr_w(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    // read data stands until the next read
    task rd_w(input logic [15:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        @(negedge clk);
        rv = rdata;
    endtask
    task loc(input logic [15:0] w);
        wr_w(16'hea10, w);
        wr_w(16'hea12, 16'h0046);
        wr_w(16'hea14, 16'h0a00);
        repeat (20) @(negedge clk);
    endtask
    task lines(input logic v);
        @(posedge clk);
        ack <= v;
        run <= v;
    endtask
    task t_off;
        lines(1);
        repeat (20) @(negedge clk);
        chk(en, 0);
        loc(16'h4102);
        chk(en, 0);
        loc(16'h4401);
        chk(en, 0);
    endtask
    task t_ok;
        loc(16'h4402);
        chk(en, 1);
        wr_w(16'hea16, 16'hffff);
        rd_w(16'hea16);
        chk(rv & 16'h0003, 0);
        rd_w(16'hea1a);
        chk(rv, 0);
        loc(16'h46ff);
        chk(en, 1);
    endtask
    task t_fail;
        lines(0);
        loc(16'h44ff);
        repeat (1010) @(negedge clk);
        rd_w(16'hea16);
        chk(rv & 16'h0003, 3);
        chk({15'h0000, rv[1]}, 16'h0001);
        loc(16'h4102);
        rd_w(16'hea16);
        chk(rv & 16'h0003, 3);
        lines(1);
        loc(16'h44ff);
        rd_w(16'hea16);
        chk(rv & 16'h0003, 0);
    endtask
    // two ticks so the new value is surely sampled
    task t_corr(input logic [15:0] v, input logic [15:0] exp, input logic [15:0] bad);
        wr_w(16'hea18, v);
        repeat (2) begin
            n = 0;
            @(negedge clk);
            while (stb !== 1'b1 && n < 200) begin
                @(negedge clk);
                n++;
            end
        end
        chk(stb, 1);
        chk(cval, exp);
        rd_w(16'hea16);
        chk(rv & 16'h8000, bad);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        t_off;
        t_ok;
        t_fail;
        t_corr(16'h0190, 16'h0190, 0);
        t_corr(16'hfe70, 16'hfe70, 0);
        t_corr(16'h0191, 0, 16'h8000);
        t_corr(16'hfe6f, 0, 16'h8000);
        t_corr(0, 0, 0);
        stop_test;
    end
    initial begin
        #400000;
        failures++;
        stop_test;
    end
endmodule
`default_nettype wire
